// ==== src/flash_cmd_sequencer.sv ====
// command sequencer of the boot firmware in flash programming mode.
// assumes the command decoder and the flash macro run on sys_clk; op_done is a
// single-cycle pulse from the macro, one per issued operation; op_fail is read only with it.
`timescale 1ns/1ps
module flash_cmd_sequencer
    import flash_timing_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = US_TICK_CYC
) (
    input  wire logic      sys_clk,
    input  wire logic      sys_rst,
    input  wire logic      cmd_valid,
    output logic           cmd_ready,
    input  wire cmd_req_t  cmd,
    output logic           op_valid,
    output flash_op_t      op,
    input  wire logic      op_done,
    input  wire logic      op_fail,
    output logic           status_valid,
    output status_t        status,
    output logic           busy
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [BLK_W-1:0] group_size(
        input logic [BLK_W-1:0] start,
        input logic [CNT_W-1:0] remain
    );
        logic [BLK_W-1:0] g;
        logic [CNT_W-1:0] sz;
        g = 9'h001;
        for (int i = 0; i <= GROUP_LOG_MAX; i++) begin
            sz = CNT_W'(1) << i;
            if (sz <= remain && (start & BLK_W'(sz - 10'h001)) == 9'h000) begin // [RULE16]
                g = BLK_W'(sz); // [RULE17]
            end
        end
        return g;
    endfunction : group_size

    function automatic win_t window_of(input cmd_req_t c);
        win_t w;
        logic [TIME_W-1:0] b;
        w = '{min_us: 32'h0000_0000, max_us: 32'h0000_0000, has_max: 1'b1};
        b = TIME_W'(c.total_blks);
        unique case (c.kind)
            CMD_CHIP_ERASE: begin
                if (c.total_blks <= GROUP_A_BLOCKS) begin
                    w.min_us = CHIP_A_MIN_US + CHIP_MIN_SLOPE_US * b; // [RULE1]
                    w.max_us = CHIP_A_MAX_US + CHIP_MAX_SLOPE_US * b; // [RULE1]
                end else begin
                    b        = b - TIME_W'(GROUP_A_BLOCKS);
                    w.min_us = CHIP_B_MIN_US + CHIP_MIN_SLOPE_US * b; // [RULE2]
                    w.max_us = CHIP_B_MAX_US + CHIP_MAX_SLOPE_US * b; // [RULE2]
                end
            end
            CMD_BLOCK_ERASE: begin
                w.min_us = BLK_ERASE_MIN_US; // [RULE4]
                w.max_us = BLK_ERASE_BASE_US + BLK_ERASE_BLK_US * TIME_W'(c.blk_cnt); // [RULE4]
            end
            CMD_PROG_CHUNK: begin
                w.min_us = PROG_CHUNK_MIN_US; // [RULE5]
                w.max_us = PROG_CHUNK_MAX_US; // [RULE5]
            end
            CMD_PROG_BLOCK: begin
                w.min_us = PROG_BLK_MIN_US; // [RULE6]
                w.max_us = (c.start_blk == 9'h000) ? PROG_BLK0_MAX_US : PROG_BLK_MAX_US; // [RULE6]
            end
            CMD_BLANK_CHECK: begin
                w.min_us = BLANK_MIN_US; // [RULE7]
                w.max_us = BLANK_MAX_US; // [RULE7]
            end
            CMD_SEC_DATA: begin
                w.max_us = SEC_DATA_MAX_US; // [RULE14]
            end
            CMD_SEC_VERIFY: begin
                w.max_us = SEC_VERIFY_MAX_US; // [RULE14]
            end
            default: begin
                w.has_max = 1'b0;
            end
        endcase
        return w;
    endfunction : window_of

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_WAIT_OP,
        ST_SETTLE,
        ST_GUARD
    } seq_state_t;

    seq_state_t           state_q;
    cmd_req_t             cmd_q;
    logic [TIME_W-1:0]    min_q;
    logic [TIME_W-1:0]    max_q;
    logic                 has_max_q;
    logic [TIME_W-1:0]    el_q;
    logic [15:0]          pre_q;
    logic                 tick;
    logic [BLK_W-1:0]     cur_blk_q;
    logic [CNT_W-1:0]     remain_q;
    logic [BLK_W-1:0]     size_q;
    logic [CNT_W-1:0]     groups_q;
    logic                 fail_q;
    logic                 cmd_ready_q;
    logic                 op_valid_q;
    flash_op_t            op_q;
    logic                 status_valid_q;
    status_t              status_q;
    logic                 accept;
    logic                 timed_out;
    logic [BLK_W-1:0]     grp;
    win_t                 win;

    assign accept    = cmd_valid && cmd_ready_q;
    assign timed_out = has_max_q && (el_q >= max_q);
    assign grp       = group_size(cur_blk_q, remain_q);
    assign win       = window_of(cmd);
    assign tick      = (pre_q == 16'(TICK_CYCLES - 1));

    // ************************************************************
    // microsecond time base
    // ************************************************************
    // restarted per command, first tick a full us later
    always_ff @(posedge sys_clk) begin
        if (sys_rst || accept || tick) begin
            pre_q <= 16'h0000;
        end else begin
            pre_q <= pre_q + 16'h0001;
        end
    end

    // saturating: a stuck macro cannot wrap below min
    always_ff @(posedge sys_clk) begin
        if (sys_rst || accept) begin
            el_q <= 32'h0000_0000;
        end else if (state_q == ST_SETTLE && status_valid_q && cmd_q.kind == CMD_BAUD_SET) begin
            el_q <= 32'h0000_0000;
        end else if (tick && el_q != 32'hFFFF_FFFF) begin
            el_q <= el_q + 32'h0000_0001;
        end
    end

    // ************************************************************
    // command capture and window
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cmd_q     <= '{kind: CMD_OTHER, default: '0};
            min_q     <= 32'h0000_0000;
            has_max_q <= 1'b0;
        end else if (accept) begin
            cmd_q     <= cmd;
            min_q     <= win.min_us;
            has_max_q <= win.has_max;
        end
    end

    // each issued group widens the deadline
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            max_q <= 32'h0000_0000;
        end else if (accept) begin
            max_q <= win.max_us;
        end else if (state_q == ST_ISSUE && cmd_q.kind == CMD_BLOCK_ERASE) begin
            max_q <= max_q + BLK_ERASE_GRP_US; // [RULE4]
        end
    end

    // ************************************************************
    // group walk over the erase range
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cur_blk_q <= 9'h000;
            remain_q  <= 10'h000;
            size_q    <= 9'h000;
            groups_q  <= 10'h000;
        end else if (accept) begin
            cur_blk_q <= cmd.start_blk;
            remain_q  <= (cmd.kind == CMD_BLOCK_ERASE) ? cmd.blk_cnt : 10'h001;
            groups_q  <= 10'h000;
        end else if (state_q == ST_ISSUE) begin
            size_q    <= (cmd_q.kind == CMD_BLOCK_ERASE) ? grp : 9'h001;
            groups_q  <= groups_q + 10'h001; // [RULE19]
        end else if (state_q == ST_WAIT_OP && op_done) begin
            cur_blk_q <= cur_blk_q + size_q; // [RULE19]
            remain_q  <= remain_q - CNT_W'(size_q); // [RULE19]
        end
    end

    // ************************************************************
    // sequence control
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            fail_q  <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        fail_q <= 1'b0;
                        if (cmd.kind == CMD_BAUD_SET) begin
                            state_q <= ST_SETTLE;
                        end else if (cmd.kind == CMD_BLOCK_ERASE && cmd.blk_cnt == 10'h000) begin
                            fail_q  <= 1'b1;
                            state_q <= ST_SETTLE;
                        end else begin
                            state_q <= ST_ISSUE;
                        end
                    end
                end
                ST_ISSUE: begin
                    state_q <= ST_WAIT_OP;
                end
                ST_WAIT_OP: begin
                    // a late done from an aborted operation is dropped in idle
                    if (op_done) begin
                        if (op_fail) begin
                            fail_q  <= 1'b1;
                            state_q <= ST_SETTLE;
                        end else if (cmd_q.kind == CMD_BLOCK_ERASE &&
                                     remain_q != CNT_W'(size_q)) begin
                            state_q <= ST_ISSUE; // [RULE15]
                        end else begin
                            state_q <= ST_SETTLE;
                        end
                    end else if (timed_out) begin
                        fail_q  <= 1'b1;
                        state_q <= ST_SETTLE; // [RULE10]
                    end
                end
                ST_SETTLE: begin
                    if (status_valid_q) begin
                        state_q <= (cmd_q.kind == CMD_BAUD_SET) ? ST_GUARD : ST_IDLE;
                    end
                end
                ST_GUARD: begin
                    if (el_q >= BAUD_GUARD_US) begin
                        state_q <= ST_IDLE; // [RULE8]
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // flash macro request
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            op_valid_q <= 1'b0;
            op_q       <= '{kind: CMD_OTHER, default: '0};
        end else begin
            op_valid_q <= (state_q == ST_ISSUE);
            if (state_q == ST_ISSUE) begin
                op_q.kind      <= cmd_q.kind;
                op_q.start_blk <= cur_blk_q;
                op_q.size      <= (cmd_q.kind == CMD_BLOCK_ERASE) ? grp : 9'h001; // [RULE17]
            end
        end
    end

    // ************************************************************
    // status frame and readiness
    // ************************************************************
    // status held back until the minimum has passed
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status_valid_q <= 1'b0;
            status_q       <= '{code: ST_ACK, group_cnt: 10'h000};
        end else begin
            status_valid_q <= 1'b0;
            if (state_q == ST_SETTLE && !status_valid_q && el_q >= min_q) begin
                status_valid_q     <= 1'b1; // [RULE10]
                status_q.group_cnt <= groups_q; // [RULE19]
                if (!fail_q) begin
                    status_q.code <= ST_ACK;
                end else if (timed_out && groups_q != 10'h000) begin
                    status_q.code <= ST_TIMEOUT;
                end else begin
                    status_q.code <= ST_WRITE_ERR;
                end
            end
        end
    end

    // ready drops the cycle a command is taken and returns with idle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cmd_ready_q <= 1'b0;
        end else if (accept) begin
            cmd_ready_q <= 1'b0;
        end else begin
            cmd_ready_q <= (state_q == ST_IDLE); // [RULE8]
        end
    end

    assign cmd_ready    = cmd_ready_q;
    assign op_valid     = op_valid_q;
    assign op           = op_q;
    assign status_valid = status_valid_q;
    assign status       = status_q;
    assign busy         = ~cmd_ready_q;

endmodule : flash_cmd_sequencer

// ==== src/flash_timing_pkg.sv ====
// Contract
// [RULE1] chip erase, up to 128 blocks: status in (60.6+5.7B) to (1112+140.9B) ms
// [RULE2] chip erase, over 128 blocks: window offsets 812.9/19403.5 ms, slopes on B-128; code uses 19403.724 ms as the maximum offset
// [RULE3] programmer picks timing group from flash size: up to 128 blocks, or more
// [RULE4] block erase: no earlier than 17.5 ms, no later than 1.1+275.5M+137.9N ms
// [RULE5] status after each 256-byte program chunk arrives within 2.8 to 47.2 ms
// [RULE6] per-block program status: 13.3 to 860.0 ms for block 0, else to 16.3 ms
// [RULE7] block blank check result arrives within 5.7 to 7.7 ms
// [RULE8] after a baud-rate set, device accepts next communication once 66.0 us pass
// [RULE9] after a baud-rate set, programmer waits at least 66.0 us before sending
// [RULE10] every other command finishes inside its window, then a status frame is sent
// [RULE11] programmer waits for the reply start bit up to the maximum, else time-out
// [RULE12] commands without maximum: receiver enabled before sending, time-out 3 s or more
// [RULE13] verify data stage: receiver enabled before each data frame, time-out 3 s or more
// [RULE14] security: data status within 20.0 us, internal-verify status within 843.7 ms; code uses 843.732 ms as the verify maximum
// [RULE15] block erase runs as a series of group erases; total wait is their sum
// [RULE16] each group covers a power-of-two number of blocks, 1 to 128
// [RULE17] group size: largest allowed not above remaining count that divides start block
// [RULE18] programmer computes the group execution count M before bounding the wait
// [RULE19] after each group, start advances and remaining falls by group size; M counts
// [RULE20] on time-out the programmer aborts the sequence and reports a time-out error
//
// shared constants and carriers of the flash command sequencer.
// assumes a 40 MHz system clock; all windows are held in whole microseconds.
package flash_timing_pkg;

    // ************************************************************
    // clock and widths
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned US_NS         = 1000;
    localparam int unsigned US_TICK_CYC   = US_NS / CLK_PERIOD_NS;
    localparam int unsigned BLK_W         = 9;
    localparam int unsigned CNT_W         = 10;
    localparam int unsigned TIME_W        = 32;

    // ************************************************************
    // windows in microseconds
    // ************************************************************
    localparam logic [31:0] CHIP_A_MIN_US     = 32'h0000_ECB8; // 60.6 ms
    localparam logic [31:0] CHIP_A_MAX_US     = 32'h0010_F7C0; // 1112 ms
    localparam logic [31:0] CHIP_B_MIN_US     = 32'h000C_6764; // 812.9 ms
    localparam logic [31:0] CHIP_B_MAX_US     = 32'h0128_13CC; // 19403.724 ms
    localparam logic [31:0] CHIP_MIN_SLOPE_US = 32'h0000_1644; // 5.7 ms per block
    localparam logic [31:0] CHIP_MAX_SLOPE_US = 32'h0002_2664; // 140.9 ms per block
    localparam logic [9:0]  GROUP_A_BLOCKS    = 10'h080;       // 128 blocks, 256 KB
    localparam logic [31:0] BLK_ERASE_MIN_US  = 32'h0000_445C; // 17.5 ms
    localparam logic [31:0] BLK_ERASE_BASE_US = 32'h0000_044C; // 1.1 ms
    localparam logic [31:0] BLK_ERASE_GRP_US  = 32'h0004_342C; // 275.5 ms per group
    localparam logic [31:0] BLK_ERASE_BLK_US  = 32'h0002_1AAC; // 137.9 ms per block
    localparam logic [31:0] PROG_CHUNK_MIN_US = 32'h0000_0AF0; // 2.8 ms
    localparam logic [31:0] PROG_CHUNK_MAX_US = 32'h0000_B860; // 47.2 ms
    localparam logic [31:0] PROG_BLK_MIN_US   = 32'h0000_33F4; // 13.3 ms
    localparam logic [31:0] PROG_BLK0_MAX_US  = 32'h000D_1F60; // 860.0 ms
    localparam logic [31:0] PROG_BLK_MAX_US   = 32'h0000_3FAC; // 16.3 ms
    localparam logic [31:0] BLANK_MIN_US      = 32'h0000_1644; // 5.7 ms
    localparam logic [31:0] BLANK_MAX_US      = 32'h0000_1E14; // 7.7 ms
    localparam logic [31:0] BAUD_GUARD_US     = 32'h0000_0042; // 66.0 us
    localparam logic [31:0] SEC_DATA_MAX_US   = 32'h0000_0014; // 20.0 us
    localparam logic [31:0] SEC_VERIFY_MAX_US = 32'h000C_DFD4; // 843.732 ms

    // ************************************************************
    // grouping and status codes
    // ************************************************************
    localparam int unsigned GROUP_LOG_MAX = 7;                 // largest group 128
    localparam logic [7:0]  ST_ACK        = 8'h06;
    localparam logic [7:0]  ST_WRITE_ERR  = 8'h1C;
    localparam logic [7:0]  ST_TIMEOUT    = 8'h1D;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef enum logic [3:0] {
        CMD_CHIP_ERASE,
        CMD_BLOCK_ERASE,
        CMD_PROG_CHUNK,
        CMD_PROG_BLOCK,
        CMD_BLANK_CHECK,
        CMD_BAUD_SET,
        CMD_SEC_DATA,
        CMD_SEC_VERIFY,
        CMD_OTHER
    } cmd_kind_t;

    typedef struct packed {
        cmd_kind_t          kind;
        logic [BLK_W-1:0]   start_blk;
        logic [CNT_W-1:0]   blk_cnt;
        logic [CNT_W-1:0]   total_blks;
    } cmd_req_t;

    typedef struct packed {
        logic [7:0]         code;
        logic [CNT_W-1:0]   group_cnt;
    } status_t;

    typedef struct packed {
        cmd_kind_t          kind;
        logic [BLK_W-1:0]   start_blk;
        logic [BLK_W-1:0]   size;
    } flash_op_t;

    typedef struct packed {
        logic [TIME_W-1:0]  min_us;
        logic [TIME_W-1:0]  max_us;
        logic               has_max;
    } win_t;

endpackage : flash_timing_pkg

// ==== verification/flash_seq_checker_sva.sv ====
// port-level checker of the flash command sequencer.
// assumes flash_timing_pkg and the single sys_clk domain of the top module.
`timescale 1ns/1ps
module flash_seq_checker
    import flash_timing_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = US_TICK_CYC
) (
    input wire logic      sys_clk,
    input wire logic      sys_rst,
    input wire logic      cmd_valid,
    input wire logic      cmd_ready,
    input wire cmd_req_t  cmd,
    input wire logic      op_valid,
    input wire flash_op_t op,
    input wire logic      op_done,
    input wire logic      op_fail,
    input wire logic      status_valid,
    input wire status_t   status,
    input wire logic      busy
);
    // ************************************************************
    // helper state, restarted per command
    // ************************************************************
    logic [31:0]      el_q;
    cmd_kind_t        kind_q;
    logic [CNT_W-1:0] ops_q;
    logic [CNT_W-1:0] rem_q;
    logic [BLK_W-1:0] nxt_q;
    logic             acc;
    int unsigned      dbl;

    assign acc = cmd_valid && cmd_ready;
    assign dbl = 2 * op.size;

    always_ff @(posedge sys_clk) begin
        if (sys_rst || acc) begin
            el_q <= 32'h0000_0000;
        end else begin
            el_q <= el_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            kind_q <= CMD_OTHER;
            ops_q  <= '0;
            rem_q  <= '0;
            nxt_q  <= '0;
        end else if (acc) begin
            kind_q <= cmd.kind;
            ops_q  <= '0;
            rem_q  <= cmd.blk_cnt;
            nxt_q  <= cmd.start_blk;
        end else if (op_valid) begin
            ops_q  <= ops_q + CNT_W'(1);
            rem_q  <= rem_q - CNT_W'(op.size);
            nxt_q  <= op.start_blk + op.size;
        end
    end

    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    AST_ERASE_MIN: assert property (status_valid && kind_q == CMD_BLOCK_ERASE &&
        status.code == ST_ACK |-> el_q >= BLK_ERASE_MIN_US * TICK_CYCLES)
        else $error("erase status too early");
    AST_CHUNK_MIN: assert property (status_valid && kind_q == CMD_PROG_CHUNK |->
        el_q >= PROG_CHUNK_MIN_US * TICK_CYCLES)
        else $error("chunk status too early");
    AST_BLANK_WIN: assert property (status_valid && kind_q == CMD_BLANK_CHECK &&
        status.code == ST_ACK |-> el_q >= BLANK_MIN_US * TICK_CYCLES &&
        el_q <= (BLANK_MAX_US + 4) * TICK_CYCLES + 4)
        else $error("blank check status out of window");
    AST_BUSY_CAP: assert property (busy && kind_q == CMD_BLANK_CHECK |->
        el_q <= (BLANK_MAX_US + 4) * TICK_CYCLES + 8)
        else $error("blank check still busy past its maximum");
    AST_BAUD_STATUS: assert property (acc && cmd.kind == CMD_BAUD_SET |->
        ##[1:4] status_valid)
        else $error("baud set status missing");
    AST_BAUD_GUARD: assert property ($rose(cmd_ready) && kind_q == CMD_BAUD_SET |->
        el_q >= BAUD_GUARD_US * TICK_CYCLES)
        else $error("ready returned inside the baud guard time");
    AST_GROUP_POW2: assert property (op_valid && op.kind == CMD_BLOCK_ERASE |->
        $onehot(op.size) && op.size <= 9'h080)
        else $error("group size not a power of two up to 128");
    AST_GROUP_LARGEST: assert property (op_valid && op.kind == CMD_BLOCK_ERASE |->
        op.size <= rem_q && op.start_blk % op.size == 0 &&
        (op.size == 9'h080 || dbl > rem_q || op.start_blk % dbl != 0))
        else $error("group not largest aligned fit");
    AST_GROUP_STEP: assert property (op_valid && op.kind == CMD_BLOCK_ERASE |->
        op.start_blk == nxt_q)
        else $error("group start not contiguous");
    AST_GROUP_CNT: assert property (status_valid |-> status.group_cnt == ops_q)
        else $error("group count differs from ops issued");
endmodule : flash_seq_checker

bind flash_cmd_sequencer flash_seq_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .op_valid(op_valid), .op(op), .op_done(op_done), .op_fail(op_fail),
    .status_valid(status_valid), .status(status), .busy(busy)
);

// ==== verification/flash_macro_model.sv ====
// behavioural flash macro answering each issued operation.
// assumes one op_done per op_valid; mode 1 fails, mode 2 never answers.
`timescale 1ns/1ps
module flash_macro_model (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        op_valid,
    input  wire logic [15:0] lat,
    input  wire logic [1:0]  mode,
    output logic             op_done,
    output logic             op_fail
);
    logic [15:0] cnt_q;
    logic        pend_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q   <= 16'h0000;
            pend_q  <= 1'b0;
            op_done <= 1'b0;
        end else if (op_valid) begin
            cnt_q   <= lat;
            pend_q  <= 1'b1;
            op_done <= 1'b0;
        end else if (pend_q && cnt_q == 16'h0000) begin
            pend_q  <= 1'b0;
            op_done <= (mode != 2'h2);
        end else begin
            cnt_q   <= cnt_q - 16'h0001;
            op_done <= 1'b0;
        end
    end

    // high outside done pulses, which the sequencer must ignore
    assign op_fail = !op_done || (mode == 2'h1);
endmodule : flash_macro_model

// ==== verification/tb_top.sv ====
// self-checking bench of the flash command sequencer.
// assumes TICK_CYCLES of 1: one microsecond is one clock.
`timescale 1ns/1ps
module tb_top;
    import flash_timing_pkg::*;
    localparam int unsigned TK = 1;

    logic        sys_clk, sys_rst, cmd_valid, cmd_ready, op_valid;
    logic        op_done, op_fail, status_valid, busy;
    cmd_req_t    cmd;
    flash_op_t   op;
    status_t     status;
    logic [15:0] lat;
    logic [1:0]  mode;
    int          failures, checks_done;
    flash_op_t   seen[$];

    flash_cmd_sequencer #(.TICK_CYCLES(TK)) DUT (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .op_valid(op_valid), .op(op), .op_done(op_done), .op_fail(op_fail),
        .status_valid(status_valid), .status(status), .busy(busy));
    flash_macro_model u_macro (.sys_clk(sys_clk), .sys_rst(sys_rst), .op_valid(op_valid),
        .lat(lat), .mode(mode), .op_done(op_done), .op_fail(op_fail));

    always #12.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (op_valid === 1'b1) begin
            seen.push_back(op);
        end
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_rng(got, exp, exp);
    endtask : check

    task automatic check_rng(input logic [31:0] got, input logic [31:0] lo,
                             input logic [31:0] hi);
        checks_done++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : check_rng

    // offer, hold until taken, count clocks to status
    task automatic run_cmd(input cmd_kind_t k, input int s, input int n, output int cyc);
        int t;
        t = 0;
        cyc = 0;
        seen.delete();
        cmd_valid <= 1'b1;
        cmd <= '{k, s[8:0], n[9:0], 10'h004};
        do begin
            @(posedge sys_clk);
            t++;
        end while (cmd_ready !== 1'b1 && t < 50);
        cmd_valid <= 1'b0;
        do begin
            @(posedge sys_clk);
            cyc++;
        end while (status_valid !== 1'b1 && cyc < 60000);
    endtask : run_cmd

    task automatic complete_run();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_erase(input int s, input int n, input int m);
        int cyc, st, rem, sz;
        run_cmd(CMD_BLOCK_ERASE, s, n, cyc);
        check(status.code, n ? ST_ACK : ST_WRITE_ERR);
        check(status.group_cnt, m);
        check(seen.size(), m);
        check_rng(cyc, BLK_ERASE_MIN_US * TK, (n ? BLK_ERASE_BASE_US + BLK_ERASE_GRP_US * m +
            BLK_ERASE_BLK_US * n : BLK_ERASE_MIN_US) * TK + 8);
        st = s;
        rem = n;
        foreach (seen[i]) begin
            sz = 128;
            while (sz > rem || st % sz != 0)
                sz = sz / 2;
            check(seen[i].start_blk, st);
            check(seen[i].size, sz);
            st += sz;
            rem -= sz;
        end
        check(rem, 0);
    endtask : t_erase

    task automatic t_single(input cmd_kind_t k, input int s, input logic [7:0] code,
                            input int lo, input int hi);
        int cyc;
        run_cmd(k, s, 1, cyc);
        check(status.code, code);
        check(seen.size(), 1);
        check_rng(cyc, lo, hi);
    endtask : t_single

    task automatic t_baud();
        int cyc, n;
        n = 0;
        run_cmd(CMD_BAUD_SET, 0, 1, cyc);
        check_rng(cyc, 1, 4);
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        check_rng(n, BAUD_GUARD_US * TK, BAUD_GUARD_US * TK + 4);
    endtask : t_baud

    initial begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        lat = 16'h0014;
        mode = 2'h0;
        failures = 0;
        checks_done = 0;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_erase(5, 6, 4);
        lat <= 16'h0BB8;
        t_erase(1, 127, 7);
        t_erase(3, 0, 0);
        check(status.code, ST_WRITE_ERR);
        lat <= 16'h0064;
        t_single(CMD_BLANK_CHECK, 2, ST_ACK, BLANK_MIN_US * TK, BLANK_MAX_US * TK + 8);
        t_single(CMD_PROG_BLOCK, 3, ST_ACK, PROG_BLK_MIN_US * TK,
            PROG_BLK_MAX_US * TK + 8);
        mode <= 2'h2;
        t_single(CMD_BLANK_CHECK, 4, ST_TIMEOUT, BLANK_MAX_US * TK,
            BLANK_MAX_US * TK + 8);
        mode <= 2'h1;
        t_single(CMD_PROG_CHUNK, 5, ST_WRITE_ERR, PROG_CHUNK_MIN_US * TK,
            PROG_CHUNK_MAX_US * TK + 8);
        mode <= 2'h0;
        t_baud();
        complete_run();
    end

    // run needs about 86000 clocks
    initial begin
        repeat (90000) @(posedge sys_clk);
        failures++;
        complete_run();
    end
endmodule : tb_top
